/* hw/css_scan_seq.v */
`timescale 1ns/1ps
`include "css_regs.vh"
module css_scan_seq #(
   parameter MS_CYCLES = `CSS_MS_NS / `CSS_CLK_PERIOD_NS,
   parameter SEC_CYCLES = `CSS_SEC_NS / `CSS_CLK_PERIOD_NS
) (
   input wire ref_clk,
   input wire rstn,
   input wire rtcRstn,
   input wire panelKeyValid,
   input wire [4:0] panelKeyCode,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   output reg [6:0] channel_reg,
   output wire relayClosed,
   output wire lampRun,
   output wire lampSingle,
   output wire lampCont,
   output wire lampChannel,
   output wire lampTime,
   output wire lampDate
);
   localparam S_IDLE = 2'h0;
   localparam S_DWELL = 2'h1;
   localparam S_BREAK = 2'h2;
   localparam S_HALT = 2'h3;
   localparam C_NONE = 2'h0;
   localparam C_INTERVAL = 2'h1;
   localparam C_PROGNUM = 2'h2;
   localparam C_PROG1 = 2'h3;
   localparam D_CHAN = 2'h0;
   localparam D_TIME = 2'h1;
   localparam D_DATE = 2'h2;
   localparam D_PROG = 2'h3;
   localparam [31:0] MS_LAST = MS_CYCLES - 1;
   localparam [31:0] SEC_LAST = SEC_CYCLES - 1;

   function [6:0] twoDig;
      input [3:0] a;
      input [3:0] b;
      begin
         twoDig = a * 7'h0a + b;
      end
   endfunction

   function [9:0] threeDig;
      input [3:0] a;
      input [3:0] b;
      input [3:0] c;
      begin
         threeDig = a * 10'h064 + b * 10'h00a + c;
      end
   endfunction

   function [4:0] daysIn;
      input [3:0] m;
      begin
         case (m)
            4'h2: daysIn = 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: daysIn = 5'h1e;
            default: daysIn = 5'h1f;
         endcase
      end
   endfunction

   reg [1:0] state_reg;
   reg [1:0] ctx_reg;
   reg [1:0] disp_reg;
   reg contMode_reg;
   reg [6:0] first_reg;
   reg [6:0] last_reg;
   reg [19:0] interval_reg;
   reg [13:0] msPre_reg;
   reg [19:0] msCnt_reg;
   reg busKeyPend_reg;
   reg [4:0] busKey_reg;
   reg wrPhase_reg;
   reg [7:0] wrAddr_reg;
   reg [23:0] secPre_reg;
   reg [4:0] hours_reg;
   reg [5:0] mins_reg;
   reg [5:0] secs_reg;
   reg [3:0] month_reg;
   reg [4:0] day_reg;
   reg dayFirst_reg;
   wire [23:0] digits;
   wire [2:0] count;

   // Key source: panel first, bus key waits while a panel key is valid
   wire keyTake = panelKeyValid | busKeyPend_reg;
   wire [4:0] keyNow = panelKeyValid ? panelKeyCode : busKey_reg;
   wire isDigit = keyTake && (keyNow <= `CSS_KEY_9);
   wire keyIs = keyTake && !isDigit;
   wire kFirst = keyIs && (keyNow == `CSS_KEY_FIRST);
   wire kLast = keyIs && (keyNow == `CSS_KEY_LAST);
   wire kInterval = keyIs && (keyNow == `CSS_KEY_INTERVAL);
   wire kEnter = keyIs && (keyNow == `CSS_KEY_ENTER);
   wire kChannel = keyIs && (keyNow == `CSS_KEY_CHANNEL);
   wire kReset = keyIs && (keyNow == `CSS_KEY_RESET);
   wire kSingle = keyIs && (keyNow == `CSS_KEY_SINGLE);
   wire kCont = keyIs && (keyNow == `CSS_KEY_CONT);
   wire kStart = keyIs && (keyNow == `CSS_KEY_STARTSTOP);
   wire kTime = keyIs && (keyNow == `CSS_KEY_TIME);
   wire kDate = keyIs && (keyNow == `CSS_KEY_DATE);
   wire kProg = keyIs && (keyNow == `CSS_KEY_PROGRAM);

   // Digits, d0 newest
   wire [3:0] d0 = digits[3:0];
   wire [3:0] d1 = digits[7:4];
   wire [3:0] d2 = digits[11:8];
   wire [3:0] d3 = digits[15:12];
   wire [3:0] d4 = digits[19:16];
   wire [3:0] d5 = digits[23:20];
   wire [6:0] pairLow = twoDig(d1, d0);
   wire [6:0] pairMid = twoDig(d3, d2);
   wire [6:0] pairHigh = twoDig(d5, d4);
   wire [9:0] entSec = threeDig(d5, d4, d3);
   wire [9:0] entMs = threeDig(d2, d1, d0);
   wire [19:0] entInterval = {10'h000, entSec} * 20'h003e8 + {10'h000, entMs};
   wire chValid = (count >= `CSS_N_TWO) && (pairLow != 7'h00) && (pairLow <= `CSS_MAX_CH);
   wire [6:0] entMonth = dayFirst_reg ? pairLow : pairMid;
   wire [6:0] entDay = dayFirst_reg ? pairMid : pairLow;

   // Entry completions
   // interval entry
   wire intLoad = kEnter && (ctx_reg == C_INTERVAL) && (count == `CSS_N_SIX);
   wire timeLoad = kEnter && (ctx_reg == C_NONE) && (disp_reg == D_TIME)
      && (count == `CSS_N_SIX) && (pairHigh < {2'h0, `CSS_HOURS})
      && (pairMid < {1'b0, `CSS_SIXTY}) && (pairLow < {1'b0, `CSS_SIXTY});
   wire dateLoad = kEnter && (ctx_reg == C_NONE) && (disp_reg == D_DATE)
      && (count == `CSS_N_FOUR) && (entMonth != 7'h00)
      && (entMonth <= {3'h0, `CSS_MONTHS}) && (entDay != 7'h00)
      && (entDay <= {2'h0, daysIn(entMonth[3:0])});
   wire orderLoad = kEnter && (ctx_reg == C_PROG1) && (count != 3'h0) && (d0 <= 4'h1);

   // Entry store: cleared by commands and program number
   css_digit_buf uDigits (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clear(keyIs || (isDigit && ctx_reg == C_PROGNUM)),
      .push(isDigit && ctx_reg != C_PROGNUM),
      .digit(keyNow[3:0]),
      .digits_reg(digits),
      .count_reg(count)
   );

   // Dwell timing
   wire msWrap = (msPre_reg == MS_LAST[13:0]);
   wire [19:0] intEff = (interval_reg == 20'h00000) ? 20'h00001 : interval_reg;
   wire dwellDone = msWrap && (msCnt_reg + 20'h00001 >= intEff);
   wire lastHit = (channel_reg == last_reg) || (channel_reg >= `CSS_MAX_CH);

   assign relayClosed = (state_reg == S_DWELL) || (state_reg == S_HALT);
   assign lampRun = (state_reg == S_DWELL) || (state_reg == S_BREAK);
   assign lampSingle = !contMode_reg;
   assign lampCont = contMode_reg;
   assign lampChannel = (disp_reg == D_CHAN);
   assign lampTime = (disp_reg == D_TIME);
   assign lampDate = (disp_reg == D_DATE);

   // Scan sequencer
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= S_IDLE;
         channel_reg <= `CSS_RST_CH;
         msPre_reg <= 14'h0000;
         msCnt_reg <= 20'h00000;
      end else if (kReset) begin
         state_reg <= S_IDLE;
         channel_reg <= first_reg;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (kStart) begin
                  state_reg <= S_DWELL;
                  channel_reg <= first_reg;
                  msPre_reg <= 14'h0000;
                  msCnt_reg <= 20'h00000;
               end
            end
            S_DWELL: begin
               if (kStart) begin
                  state_reg <= S_HALT;
               end else if (dwellDone) begin
                  state_reg <= S_BREAK;
               end else begin
                  msPre_reg <= msWrap ? 14'h0000 : msPre_reg + 14'h0001;
                  msCnt_reg <= msWrap ? msCnt_reg + 20'h00001 : msCnt_reg;
               end
            end
            S_BREAK: begin
               msPre_reg <= 14'h0000;
               msCnt_reg <= 20'h00000;
               if (kStart) begin
                  state_reg <= S_HALT;
               end else if (lastHit && !contMode_reg) begin
                  state_reg <= S_IDLE;
               end else if (lastHit) begin
                  state_reg <= S_DWELL;
                  channel_reg <= first_reg;
               end else begin
                  state_reg <= S_DWELL;
                  channel_reg <= channel_reg + 7'h01;
               end
            end
            S_HALT: begin
               if (kStart) begin
                  state_reg <= S_DWELL;
                  msPre_reg <= 14'h0000;
                  msCnt_reg <= 20'h00000;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // Keypad command handling and setup
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctx_reg <= C_NONE;
         disp_reg <= D_CHAN;
         contMode_reg <= 1'b0;
         first_reg <= `CSS_RST_CH;
         last_reg <= `CSS_RST_CH;
         interval_reg <= `CSS_RST_INTERVAL;
      end else begin
         if (keyIs) begin
            ctx_reg <= C_NONE;
         end
         if (kFirst && chValid) begin
            first_reg <= pairLow;
         end
         if (kLast && chValid) begin
            last_reg <= pairLow;
         end
         if (kInterval) begin
            ctx_reg <= C_INTERVAL;
         end
         if (intLoad) begin
            interval_reg <= entInterval;
         end
         if (kChannel) begin
            disp_reg <= D_CHAN;
         end
         if (kSingle) begin
            contMode_reg <= 1'b0;
         end
         if (kCont) begin
            contMode_reg <= 1'b1;
         end
         if (kTime) begin
            disp_reg <= D_TIME;
         end
         if (kDate) begin
            disp_reg <= D_DATE;
         end
         if (kProg) begin
            ctx_reg <= C_PROGNUM;
            disp_reg <= D_PROG;
         end
         if (isDigit && ctx_reg == C_PROGNUM) begin
            ctx_reg <= (keyNow[3:0] == `CSS_PROG_DATE) ? C_PROG1 : C_NONE;
         end
         if (kEnter && ctx_reg == C_PROG1) begin
            disp_reg <= D_DATE;
         end
      end
   end

   always @(posedge ref_clk or negedge rtcRstn) begin
      if (!rtcRstn) begin
         secPre_reg <= 24'h000000;
         hours_reg <= 5'h00;
         mins_reg <= 6'h00;
         secs_reg <= 6'h00;
         month_reg <= `CSS_RST_MONTH;
         day_reg <= `CSS_RST_DAY;
         dayFirst_reg <= 1'b0;
      end else begin
         if (orderLoad) begin
            dayFirst_reg <= d0[0];
         end
         if (dateLoad) begin
            month_reg <= entMonth[3:0];
            day_reg <= entDay[4:0];
         end
         if (timeLoad) begin
            secPre_reg <= 24'h000000;
            hours_reg <= pairHigh[4:0];
            mins_reg <= pairMid[5:0];
            secs_reg <= pairLow[5:0];
         end else if (secPre_reg != SEC_LAST[23:0]) begin
            secPre_reg <= secPre_reg + 24'h000001;
         end else begin
            secPre_reg <= 24'h000000;
            secs_reg <= (secs_reg == `CSS_SIXTY - 6'h01) ? 6'h00 : secs_reg + 6'h01;
            if (secs_reg == `CSS_SIXTY - 6'h01) begin
               mins_reg <= (mins_reg == `CSS_SIXTY - 6'h01) ? 6'h00 : mins_reg + 6'h01;
            end
            if (secs_reg == `CSS_SIXTY - 6'h01 && mins_reg == `CSS_SIXTY - 6'h01) begin
               hours_reg <= (hours_reg == `CSS_HOURS - 5'h01) ? 5'h00 : hours_reg + 5'h01;
               if (hours_reg == `CSS_HOURS - 5'h01 && !dateLoad) begin
                  if (day_reg >= daysIn(month_reg)) begin
                     day_reg <= `CSS_RST_DAY;
                     month_reg <= (month_reg == `CSS_MONTHS) ? `CSS_RST_MONTH
                        : month_reg + 4'h1;
                  end else begin
                     day_reg <= day_reg + 5'h01;
                  end
               end
            end
         end
      end
   end

   // AHB-Lite slave, zero wait states
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   wire addrPhase = hsel && htrans[1] && hready;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPhase_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         busKeyPend_reg <= 1'b0;
         busKey_reg <= 5'h00;
         hrdata <= 32'h00000000;
      end else begin
         wrPhase_reg <= addrPhase && hwrite;
         wrAddr_reg <= haddr[7:0];
         if (wrPhase_reg && wrAddr_reg == `CSS_OFF_KEY
            && hwdata[`CSS_KEY_STROBE_BIT]) begin
            busKeyPend_reg <= 1'b1;
            busKey_reg <= hwdata[4:0];
         end else if (!panelKeyValid) begin
            busKeyPend_reg <= 1'b0;
         end
         if (addrPhase && !hwrite) begin
            case (haddr[7:0])
               `CSS_OFF_STATUS: hrdata <= {16'h0000, lampDate, lampTime, lampChannel,
                  lampCont, lampRun, relayClosed, state_reg, busKeyPend_reg, channel_reg};
               `CSS_OFF_SETUP: hrdata <= {17'h00000, last_reg, 1'b0, first_reg};
               `CSS_OFF_INTERVAL: hrdata <= {12'h000, interval_reg};
               `CSS_OFF_TIME: hrdata <= {11'h000, hours_reg, 2'h0, mins_reg, 2'h0, secs_reg};
               `CSS_OFF_DATE: hrdata <= {15'h0000, dayFirst_reg, 3'h0, day_reg, 4'h0,
                  month_reg};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // css_scan_seq

/* hw/css_regs.vh */
`ifndef CSS_REGS_VH
`define CSS_REGS_VH
// Key codes of the front panel
`define CSS_KEY_9 5'h09
`define CSS_KEY_FIRST 5'h0a
`define CSS_KEY_LAST 5'h0b
`define CSS_KEY_INTERVAL 5'h0c
`define CSS_KEY_ENTER 5'h0d
`define CSS_KEY_CHANNEL 5'h0e
`define CSS_KEY_RESET 5'h0f
`define CSS_KEY_SINGLE 5'h10
`define CSS_KEY_CONT 5'h11
`define CSS_KEY_STARTSTOP 5'h12
`define CSS_KEY_TIME 5'h13
`define CSS_KEY_DATE 5'h14
`define CSS_KEY_PROGRAM 5'h15
// Register byte offsets and key strobe bit
`define CSS_OFF_KEY 8'h00
`define CSS_OFF_STATUS 8'h04
`define CSS_OFF_SETUP 8'h08
`define CSS_OFF_INTERVAL 8'h0c
`define CSS_OFF_TIME 8'h10
`define CSS_OFF_DATE 8'h14
`define CSS_KEY_STROBE_BIT 8
// Timing
`define CSS_CLK_PERIOD_NS 100
`define CSS_MS_NS 1000000
`define CSS_SEC_NS 1000000000
// Limits, digit counts and the date-order program number
`define CSS_MAX_CH 7'h63
`define CSS_HOURS 5'h18
`define CSS_SIXTY 6'h3c
`define CSS_MONTHS 4'hc
`define CSS_N_SIX 3'h6
`define CSS_N_FOUR 3'h4
`define CSS_N_TWO 3'h2
`define CSS_PROG_DATE 4'h1
// Reset values
`define CSS_RST_CH 7'h01
`define CSS_RST_INTERVAL 20'h003e8
`define CSS_RST_MONTH 4'h1
`define CSS_RST_DAY 5'h01
`endif

/* hw/css_digit_buf.v */
`timescale 1ns/1ps
// Six-digit keypad entry store, newest digit in the low nibble
module css_digit_buf (
   input wire ref_clk,
   input wire rstn,
   input wire clear,
   input wire push,
   input wire [3:0] digit,
   output reg [23:0] digits_reg,
   output reg [2:0] count_reg
);
`include "css_regs.vh"
   // Shift in digits; a seventh digit restarts the entry
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         digits_reg <= 24'h000000;
         count_reg <= 3'h0;
      end else if (clear) begin
         digits_reg <= 24'h000000;
         count_reg <= 3'h0;
      end else if (push) begin
         if (count_reg == `CSS_N_SIX) begin
            digits_reg <= {20'h00000, digit};
            count_reg <= 3'h1;
         end else begin
            digits_reg <= {digits_reg[19:0], digit};
            count_reg <= count_reg + 3'h1;
         end
      end
   end
endmodule // css_digit_buf

/* tb/css_scan_seq_chk_properties.sv */
`timescale 1ns/1ps
`include "css_regs.vh"
// Port checks of scan sequencing and panel lamps
module css_scan_seq_chk #(
   parameter MS_CYCLES = 4,
   parameter SEC_CYCLES = 20
) (
   input wire ref_clk,
   input wire rstn,
   input wire panelKeyValid,
   input wire [4:0] panelKeyCode,
   input wire [6:0] channel_reg,
   input wire relayClosed,
   input wire lampRun,
   input wire lampSingle,
   input wire lampCont,
   input wire lampChannel,
   input wire lampTime,
   input wire lampDate
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire dwellSt;
   wire keySs;
   // Decodes of dwell state and start/stop key
   assign dwellSt = relayClosed & lampRun;
   assign keySs = panelKeyValid & (panelKeyCode == `CSS_KEY_STARTSTOP);
   function automatic logic isKey(input logic v, input logic [4:0] c, input logic [4:0] k);
      isKey = v && (c == k);
   endfunction
   property p_single;
      isKey(panelKeyValid, panelKeyCode, `CSS_KEY_SINGLE) |=> lampSingle && !lampCont;
   endproperty
   a_single: assert property (p_single) else $error("single lamp off");
   property p_time;
      isKey(panelKeyValid, panelKeyCode, `CSS_KEY_TIME) |=> lampTime && !lampDate;
   endproperty
   a_time: assert property (p_time) else $error("time lamp off");
   property p_date;
      isKey(panelKeyValid, panelKeyCode, `CSS_KEY_DATE) |=> lampDate && !lampTime;
   endproperty
   a_date: assert property (p_date) else $error("date lamp off");
   property p_reset;
      isKey(panelKeyValid, panelKeyCode, `CSS_KEY_RESET) |=> !relayClosed && !lampRun;
   endproperty
   a_reset: assert property (p_reset) else $error("reset left scan on");
   property p_start;
      keySs && !relayClosed && !lampRun |=> dwellSt;
   endproperty
   a_start: assert property (p_start) else $error("start failed");
   property p_halt;
      keySs && dwellSt |=> relayClosed && !lampRun && $stable(channel_reg);
   endproperty
   a_halt: assert property (p_halt) else $error("halt failed");
   property p_resume;
      keySs && relayClosed && !lampRun |=> dwellSt && $stable(channel_reg);
   endproperty
   a_resume: assert property (p_resume) else $error("resume failed");
   property p_dwell;
      $rose(dwellSt) ##1 (!panelKeyValid)[*3] |-> relayClosed;
   endproperty
   a_dwell: assert property (p_dwell) else $error("dwell cut short");
   property p_adv;
      lampRun && !relayClosed && !panelKeyValid |=> !lampRun || $changed(channel_reg);
   endproperty
   a_adv: assert property (p_adv) else $error("no advance after break");
   c_halt: cover property (keySs && dwellSt);
   c_break: cover property (lampRun && !relayClosed);
   c_end: cover property ($fell(lampRun) && !relayClosed);
endmodule // css_scan_seq_chk

/* tb/css_panel_model.sv */
`timescale 1ns/1ps
// Keypad: one-cycle strobe per request
module css_panel_model (
   input wire ref_clk,
   input wire rstn,
   input wire pressReq,
   input wire [4:0] pressCode,
   output reg panelKeyValid,
   output reg [4:0] panelKeyCode
);
   // Idle code toggles so it never looks like a held key
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         panelKeyValid <= 1'b0;
         panelKeyCode <= 5'h1f;
      end else begin
         panelKeyValid <= pressReq;
         panelKeyCode <= pressReq ? pressCode : ~panelKeyCode;
      end
   end
endmodule // css_panel_model

/* tb/css_scan_seq_bench.sv */
`timescale 1ns/1ps
`include "css_regs.vh"
module css_scan_seq_bench;
   localparam MS = 4;
   reg ref_clk = 1'b0;
   reg rstn = 1'b0;
   reg rtcRstn = 1'b0;
   reg pressReq = 1'b0;
   reg [4:0] pressCode = 5'h00;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] hwdata = 32'h0;
   wire panelKeyValid, hreadyout, hresp, relayClosed, lampRun, lampSingle;
   wire lampCont, lampChannel, lampTime, lampDate;
   wire [4:0] panelKeyCode;
   wire [31:0] hrdata;
   wire [6:0] channel_reg;
   integer nErrors = 0, checkCount = 0, seed, mFirst, mLast, k, n;
   integer expCh[$];
   logic [31:0] q;
   // Clock, 100 ns period
   always #50 ref_clk = ~ref_clk;
   css_panel_model i_css_panel_model (.ref_clk(ref_clk), .rstn(rstn), .pressReq(pressReq),
      .pressCode(pressCode), .panelKeyValid(panelKeyValid), .panelKeyCode(panelKeyCode));
   css_scan_seq #(.MS_CYCLES(MS), .SEC_CYCLES(20)) i_css_scan_seq (.ref_clk(ref_clk),
      .rstn(rstn), .rtcRstn(rtcRstn), .panelKeyValid(panelKeyValid),
      .panelKeyCode(panelKeyCode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .channel_reg(channel_reg),
      .relayClosed(relayClosed), .lampRun(lampRun), .lampSingle(lampSingle),
      .lampCont(lampCont), .lampChannel(lampChannel), .lampTime(lampTime), .lampDate(lampDate));
   task close_out;
      begin
         if (nErrors == 0 && checkCount > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task cmp_pin(input logic [31:0] got, input logic [31:0] exp);
      begin
         checkCount = checkCount + 1;
         if (got !== exp) begin
            nErrors = nErrors + 1;
            $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task cmp_bus(input logic [31:0] got, input logic [31:0] exp);
      begin
         checkCount = checkCount + 1;
         if (got !== exp) begin
            nErrors = nErrors + 1;
            $display("[ERR] %0t bus got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Bounded wait for hready at a rising edge
   task wait_rdy;
      integer i;
      begin
         i = 0;
         @(posedge ref_clk);
         while (hreadyout !== 1'b1 && i < 50) begin
            i = i + 1;
            @(posedge ref_clk);
         end
         if (i >= 50) begin
            nErrors = nErrors + 1;
            close_out;
         end
      end
   endtask
   // One single word transfer
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      begin
         @(posedge ref_clk);
         hsel <= 1'b1;
         haddr <= a;
         htrans <= 2'h2;
         hwrite <= wr;
         wait_rdy;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         wait_rdy;
         r = hrdata;
      end
   endtask
   task press(input logic [4:0] c);
      begin
         @(posedge ref_clk);
         pressReq <= 1'b1;
         pressCode <= c;
         @(posedge ref_clk);
         pressReq <= 1'b0;
      end
   endtask
   // Key string, one code per byte, leftmost first
   task keys(input logic [63:0] s, input integer cnt);
      integer i;
      begin
         for (i = cnt - 1; i >= 0; i = i - 1)
            press(s[8*i +: 5]);
      end
   endtask
   task setch(input integer ch, input logic [4:0] key);
      begin
         press(5'(ch / 10));
         press(5'(ch % 10));
         press(key);
      end
   endtask
   task settle;
      begin
         @(posedge ref_clk);
         @(negedge ref_clk);
      end
   endtask
   // Runaway guard
   initial begin
      #(100 * 60000);
      nErrors = nErrors + 1;
      close_out;
   end
   // Main sequence
   initial begin
      seed = 57886;
      mFirst = 2 + ({$random(seed)} % 40);
      mLast = mFirst + 2 + ({$random(seed)} % 3);
      n = mLast - mFirst + 1;
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      rtcRstn <= 1'b1;
      ahb(1'b0, 32'h08, 32'h0, q); cmp_bus(q, 32'h0101);
      ahb(1'b0, 32'h0c, 32'h0, q); cmp_bus(q, 32'h3e8);
      ahb(1'b0, 32'h14, 32'h0, q); cmp_bus(q, 32'h0101);
      ahb(1'b0, 32'h20, 32'h0, q); cmp_bus(q, 32'h0);
      cmp_pin(hresp, 32'h0);
      setch(0, `CSS_KEY_FIRST);
      setch(mFirst, `CSS_KEY_FIRST);
      setch(mLast, `CSS_KEY_LAST);
      ahb(1'b0, 32'h08, 32'h0, q); cmp_bus(q, 32'(mLast * 256 + mFirst));
      keys(64'h0c0001020304050d, 8);
      ahb(1'b0, 32'h0c, 32'h0, q); cmp_bus(q, 32'd12345);
      keys(64'h0c0000000000020d, 8);
      keys(64'h0e0f, 2);
      settle; cmp_pin(channel_reg, mFirst); cmp_pin(lampChannel, 1);
      press(`CSS_KEY_SINGLE);
      settle; cmp_pin(lampSingle, 1);
      for (k = mFirst; k <= mLast; k = k + 1) expCh.push_back(k);
      press(`CSS_KEY_STARTSTOP);
      @(posedge ref_clk);
      while (expCh.size() > 0) begin
         @(negedge ref_clk);
         cmp_pin({relayClosed, lampRun, channel_reg}, {2'b11, 7'(expCh.pop_front())});
         repeat (2 * MS) @(negedge ref_clk);
         cmp_pin(relayClosed, 0);
      end
      @(negedge ref_clk);
      cmp_pin({lampRun, channel_reg}, {1'b0, 7'(mLast)});
      ahb(1'b1, 32'h00, 32'h111, q);
      repeat (2) @(posedge ref_clk);
      settle; cmp_pin({lampCont, lampSingle}, 2'b10);
      press(`CSS_KEY_STARTSTOP);
      @(posedge ref_clk);
      repeat (n * (2 * MS + 1) + 1) @(negedge ref_clk);
      cmp_pin(channel_reg, mFirst);
      press(`CSS_KEY_STARTSTOP);
      settle; cmp_pin({relayClosed, lampRun, channel_reg}, {2'b10, 7'(mFirst)});
      repeat (30) @(negedge ref_clk);
      cmp_pin({relayClosed, channel_reg}, {1'b1, 7'(mFirst)});
      press(`CSS_KEY_STARTSTOP);
      settle; cmp_pin({lampRun, channel_reg}, {1'b1, 7'(mFirst)});
      repeat (2 * MS + 1) @(negedge ref_clk);
      cmp_pin(channel_reg, mFirst + 1);
      press(`CSS_KEY_RESET);
      settle; cmp_pin({relayClosed, lampRun, channel_reg}, {2'b00, 7'(mFirst)});
      keys(64'h130109030000000d, 8);
      settle; cmp_pin(lampTime, 1);
      keys(64'h130205000000000d, 8);
      settle;
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      ahb(1'b0, 32'h10, 32'h0, q); cmp_bus(q & 32'h1f3f00, 32'h131e00);
      keys(64'h1501010d, 4);
      settle; cmp_pin(lampDate, 1);
      keys(64'h14010800080d, 6);
      keys(64'h14000d1502000d, 7);
      ahb(1'b0, 32'h14, 32'h0, q); cmp_bus(q, 32'h11208);
      keys(64'h1501000d, 4);
      keys(64'h14000801080d, 6);
      ahb(1'b0, 32'h14, 32'h0, q); cmp_bus(q, 32'h01208);
      close_out;
   end
endmodule // css_scan_seq_bench
bind css_scan_seq css_scan_seq_chk #(.MS_CYCLES(MS_CYCLES), .SEC_CYCLES(SEC_CYCLES)) i_chk (
   .ref_clk(ref_clk), .rstn(rstn), .panelKeyValid(panelKeyValid),
   .panelKeyCode(panelKeyCode), .channel_reg(channel_reg), .relayClosed(relayClosed),
   .lampRun(lampRun), .lampSingle(lampSingle), .lampCont(lampCont),
   .lampChannel(lampChannel), .lampTime(lampTime), .lampDate(lampDate));
